// ---- inc/sensor_defs.svh ----
// register offsets, field positions, reset values and codes of the sensor link
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH
// frame fields
`define F_WR        31
`define F_ADDR_HI   30
`define F_ADDR_LO   26
`define F_RS_HI     25
`define F_RS_LO     24
`define F_DATA_HI   23
`define F_DATA_LO   8
`define F_CRC_HI    7
// device register addresses
`define REG_STATUS  5'h06
`define REG_ERR1    5'h07
`define REG_ERR2    5'h08
`define REG_ANGLE   5'h0c
`define REG_CMD     5'h0d
// return status codes
`define RS_OK       2'b01
`define RS_ERR      2'b11
// command values
`define CMD_PD      16'h0004
`define CMD_SWRST   16'h0020
`define CMD_MODE_HI 16'h0003
// implemented flag bits of the detailed error registers
`define ERR1_MASK   16'h0fff
`define ERR2_MASK   16'h7bbf
// detailed flag positions driven by the device itself
`define E2_MODE_CHG 9
`define E2_PD       8
`define E2_DIGITAL_POWER_FAULT     4
// summary bit positions
`define S_CLK       7
`define S_SAT       6
`define S_TEMP      5
`define S_PWR       4
`define S_MEM       3
`define S_PD        2
`define S_MODE      1
`define S_PIN       0
// reset values
`define MODE_RESET  2'h0
`define ANG_RESET   5'h00
`define WORD_ZERO   16'h0000
// checksum
`define CRC_POLY    8'h1d
`define CRC_INIT    8'hff
`define CRC_XOROUT  8'hff
// host register offsets
`define H_TX        8'h00
`define H_RX        8'h04
`define H_STAT      8'h08
// host status bit positions
`define HS_RXNEW    0
`define HS_CRCBAD   1
`define HS_BUSY     2
`define HS_ERR      3
`endif

// ---- inc/sensor_pkg.sv ----
// shared types of the sensor register link
package sensor_pkg;
  typedef logic [31:0] frame_t;
  typedef logic [23:0] payload_t;
  typedef logic [15:0] word_t;
  typedef logic [1:0]  mode_t;
  typedef logic [4:0]  addr_t;
  typedef enum logic {H_IDLE, H_WAIT} host_state_e;
endpackage : sensor_pkg

// ---- inc/frame_if.sv ----
// frame link between host controller and sensor register bank
`timescale 1ns/1ps
interface frame_if;
  logic                req_valid;
  sensor_pkg::frame_t  req_frame;
  logic                rsp_valid;
  sensor_pkg::frame_t  rsp_frame;
  modport dev  (input  req_valid, input  req_frame,
                output rsp_valid, output rsp_frame);
  modport host (output req_valid, output req_frame,
                input  rsp_valid, input  rsp_frame);
endinterface : frame_if

// ---- hw/crc8_calc.sv ----
// frame checksum over the upper 24 bits of a frame
`timescale 1ns/1ps
`include "sensor_defs.svh"
module crc8_calc (
  // payload
  input  wire logic [23:0] data,
  // checksum
  output logic [7:0]       crc
);
  import sensor_pkg::*;
  logic [7:0] acc;
  always_comb begin
    acc = `CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (acc[7] ^ data[i]) begin
        acc = {acc[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        acc = {acc[6:0], 1'b0};
      end
    end
    crc = acc ^ `CRC_XOROUT;
  end
endmodule : crc8_calc

// ---- hw/sensor_regs_dev.sv ----
// sensor side: error flags, status summary, command and angle registers
// Summary of operation
// - reading status summary clears its latch
// - each response answers the previous frame
// - return status 11 while error latched
// - summary combines both detailed flag registers
// - detailed flag reads clear nothing
// - detailed flags read-only at 07h, 08h
// - primary flags: converter, front end, memory
// - secondary flags: caps, ground, supply, power, clock
// - digital power flag set after any reset
// - command register: mode, power down, reset
// - host selects modes with fixed frames
// - power down entered and left by command
// - reset bit alone triggers full reset
// - command register readable by host
// - resets and waking from power down return mode one
// - mode or power change sets summary bits
// - host writes only valid command values
// - write-only 5-bit angle enable, reset zero
// - summary is read-only word at 06h
// - summary bits: saturation, power, down, mode
`timescale 1ns/1ps
`include "sensor_defs.svh"
module sensor_regs_dev (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // frame link
  frame_if.dev                link,
  // live fault sources from the sensing path
  input  wire logic [15:0]    err1_src,
  input  wire logic [15:0]    err2_src,
  // control outputs
  output sensor_pkg::mode_t   op_mode,
  output logic                power_down,
  output logic [4:0]          angle_enable,
  output logic                soft_reset
);
  import sensor_pkg::*;

  // summary bits as a combination of the detailed flags
  function automatic word_t summarize(input word_t e1, input word_t e2);
    word_t s;
    s          = `WORD_ZERO;
    s[`S_PIN]  = |e2[14:12];
    s[`S_MODE] = e2[9];
    s[`S_PD]   = e2[8];
    s[`S_MEM]  = e1[0] | e2[7];
    s[`S_PWR]  = e2[11] | e2[5] | e2[4] | e2[3] | e2[2];
    s[`S_TEMP] = e2[1];
    s[`S_SAT]  = |e1[11:1];
    s[`S_CLK]  = e2[0];
    return s;
  endfunction : summarize

  // state
  frame_t   pend_q;
  mode_t    mode_q,     mode_d;
  logic     pd_q,       pd_d;
  logic [4:0] ang_q,    ang_d;
  logic     mchg_q,     mchg_d;
  logic     pchg_q,     pchg_d;
  logic     digital_power_fault_q,     digital_power_fault_d;
  word_t    status_q,   status_d;
  logic     srst_q;
  frame_t   rsp_q;
  logic     rsp_valid_q;

  // incoming frame decode
  payload_t   rx_payload;
  logic [7:0] rx_crc;
  logic       frame_ok;
  logic       rx_wr;
  addr_t      rx_addr;
  word_t      rx_data;
  assign rx_payload = link.req_frame[31:8];
  crc8_calc u_rx_crc (
    .data (rx_payload),
    .crc  (rx_crc)
  );
  // a frame with a bad checksum is answered but never executed
  assign frame_ok = link.req_valid
                  && (rx_crc == link.req_frame[`F_CRC_HI:0]);
  assign rx_wr    = link.req_frame[`F_WR];
  assign rx_addr  = link.req_frame[`F_ADDR_HI:`F_ADDR_LO];
  assign rx_data  = link.req_frame[`F_DATA_HI:`F_DATA_LO];

  logic wr_cmd;
  logic wr_ang;
  logic cmd_mode;
  logic cmd_pd;
  logic cmd_rst;
  assign wr_cmd   = frame_ok && rx_wr && (rx_addr == `REG_CMD);
  assign wr_ang   = frame_ok && rx_wr && (rx_addr == `REG_ANGLE);
  // other values are not decoded and leave the state untouched
  assign cmd_mode = wr_cmd && (rx_data <= `CMD_MODE_HI);
  assign cmd_pd   = wr_cmd && (rx_data == `CMD_PD);
  assign cmd_rst  = wr_cmd && (rx_data == `CMD_SWRST);

  // detailed flag views, reserved bits forced low
  word_t err1_w;
  word_t err2_w;
  word_t own2_w;
  always_comb begin
    own2_w               = `WORD_ZERO;
    own2_w[`E2_MODE_CHG] = mchg_q;
    own2_w[`E2_PD]       = pd_q | pchg_q;
    own2_w[`E2_DIGITAL_POWER_FAULT]     = digital_power_fault_q;
  end
  assign err1_w = err1_src & `ERR1_MASK;
  assign err2_w = (err2_src & `ERR2_MASK) | own2_w;

  // answer to the pending frame
  logic  pend_wr;
  addr_t pend_addr;
  logic  clr_sum;
  assign pend_wr   = pend_q[`F_WR];
  assign pend_addr = pend_q[`F_ADDR_HI:`F_ADDR_LO];
  // only the summary read clears; detailed reads have no side effect
  assign clr_sum   = link.req_valid && !pend_wr
                   && (pend_addr == `REG_STATUS);

  word_t rd_data;
  always_comb begin
    case (pend_addr)
      `REG_STATUS: rd_data = status_q;
      `REG_ERR1:   rd_data = err1_w;
      `REG_ERR2:   rd_data = err2_w;
      `REG_CMD:    rd_data = {11'h000, 2'b00, pd_q, mode_q};
      default:     rd_data = `WORD_ZERO;
    endcase
  end

  word_t    tx_data;
  payload_t tx_payload;
  logic [7:0] tx_crc;
  logic [1:0] tx_rs;
  // writes echo their data, reads return the register
  assign tx_data    = pend_wr ? pend_q[`F_DATA_HI:`F_DATA_LO] : rd_data;
  assign tx_rs      = (status_q != `WORD_ZERO) ? `RS_ERR : `RS_OK;
  assign tx_payload = {pend_q[`F_WR:`F_ADDR_LO], tx_rs, tx_data};
  crc8_calc u_tx_crc (
    .data (tx_payload),
    .crc  (tx_crc)
  );

  // command, mode and event next state
  always_comb begin
    mode_d = mode_q;
    pd_d   = pd_q;
    mchg_d = mchg_q && !clr_sum;
    pchg_d = pchg_q && !clr_sum;
    digital_power_fault_d = digital_power_fault_q && !clr_sum;
    ang_d  = wr_ang ? rx_data[4:0] : ang_q;
    if (cmd_pd) begin
      pd_d = 1'b1;
      if (!pd_q) begin
        pchg_d = 1'b1;
      end
    end else if (cmd_mode && pd_q) begin
      // waking always lands in mode one
      pd_d   = 1'b0;
      mode_d = `MODE_RESET;
      pchg_d = 1'b1;
    end else if (cmd_mode) begin
      mode_d = rx_data[1:0];
      if (rx_data[1:0] != mode_q) begin
        mchg_d = 1'b1;
      end
    end
  end

  // the summary latches the flags' next values, so a sticky flag cleared
  // by this read cannot slip back into the word it was just cleared from
  word_t own2_d;
  word_t err2_nx;
  always_comb begin
    own2_d               = `WORD_ZERO;
    own2_d[`E2_MODE_CHG] = mchg_d;
    own2_d[`E2_PD]       = pd_d | pchg_d;
    own2_d[`E2_DIGITAL_POWER_FAULT]     = digital_power_fault_d;
  end
  assign err2_nx = (err2_src & `ERR2_MASK) | own2_d;

  // events set after the clear so a coincident fault is kept
  assign status_d = (clr_sum ? `WORD_ZERO : status_q)
                  | summarize(err1_w, err2_nx);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= cmd_rst;
    end
  end

  // a software reset puts every register but the pending frame and the response back to its power-on value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `MODE_RESET;
      pd_q   <= 1'b0;
      ang_q  <= `ANG_RESET;
      mchg_q <= 1'b0;
      pchg_q <= 1'b0;
      digital_power_fault_q <= 1'b1;
    end else if (srst_q) begin
      mode_q <= `MODE_RESET;
      pd_q   <= 1'b0;
      ang_q  <= `ANG_RESET;
      mchg_q <= 1'b0;
      pchg_q <= 1'b0;
      digital_power_fault_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      pd_q   <= pd_d;
      ang_q  <= ang_d;
      mchg_q <= mchg_d;
      pchg_q <= pchg_d;
      digital_power_fault_q <= digital_power_fault_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= `WORD_ZERO;
    end else if (srst_q) begin
      status_q <= `WORD_ZERO;
    end else begin
      status_q <= status_d;
    end
  end

  // the pending frame is what the next response will answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= '0;
    end else if (link.req_valid) begin
      pend_q <= frame_ok ? link.req_frame : '0;
    end
  end

  // a response leaves the cycle after the next frame arrived
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= link.req_valid;
      if (link.req_valid) begin
        rsp_q <= {tx_payload, tx_crc};
      end
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_frame = rsp_q;
  assign op_mode        = mode_q;
  assign power_down     = pd_q;
  assign angle_enable   = ang_q;
  assign soft_reset     = srst_q;
endmodule : sensor_regs_dev

// ---- hw/sensor_host_ctrl.sv ----
// host side: APB registers that send frames and collect responses
`timescale 1ns/1ps
`include "sensor_defs.svh"
module sensor_host_ctrl (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // frame link
  frame_if.host               link
);
  import sensor_pkg::*;

  host_state_e state_q;
  frame_t      tx_q;
  logic        req_valid_q;
  frame_t      rx_q;
  logic        rxnew_q;
  logic        crcbad_q;

  logic access;
  logic sel_tx;
  logic sel_rx;
  logic sel_stat;
  logic unmapped;
  logic tx_go;
  logic rx_rd;
  assign access   = psel && penable;
  assign sel_tx   = (paddr == `H_TX);
  assign sel_rx   = (paddr == `H_RX);
  assign sel_stat = (paddr == `H_STAT);
  assign unmapped = !(sel_tx || sel_rx || sel_stat);
  // a send waits in the access phase until the last answer is back
  assign pready   = !(sel_tx && pwrite) || (state_q == H_IDLE);
  assign pslverr  = access && unmapped;
  assign tx_go    = access && pwrite && sel_tx && (state_q == H_IDLE);
  assign rx_rd    = access && pready && !pwrite && sel_rx;

  // checksum for the outgoing payload and the incoming response
  logic [7:0] tx_crc;
  logic [7:0] rx_crc;
  crc8_calc u_tx_crc (
    .data (pwdata[23:0]),
    .crc  (tx_crc)
  );
  crc8_calc u_rx_crc (
    .data (link.rsp_frame[31:8]),
    .crc  (rx_crc)
  );

  word_t stat_w;
  always_comb begin
    stat_w             = `WORD_ZERO;
    stat_w[`HS_RXNEW]  = rxnew_q;
    stat_w[`HS_CRCBAD] = crcbad_q;
    stat_w[`HS_BUSY]   = (state_q == H_WAIT);
    stat_w[`HS_ERR]    = (rx_q[`F_RS_HI:`F_RS_LO] == `RS_ERR);
  end
  assign prdata = sel_tx   ? tx_q
                : sel_rx   ? rx_q
                : sel_stat ? {16'h0000, stat_w}
                : 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= H_IDLE;
      req_valid_q <= 1'b0;
      tx_q        <= '0;
    end else begin
      req_valid_q <= tx_go;
      case (state_q)
        H_IDLE: begin
          if (tx_go) begin
            tx_q    <= {pwdata[23:0], tx_crc};
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // the captured answer belongs to the frame sent before this one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_q     <= '0;
      rxnew_q  <= 1'b0;
      crcbad_q <= 1'b0;
    end else begin
      if (link.rsp_valid) begin
        rx_q     <= link.rsp_frame;
        crcbad_q <= (rx_crc != link.rsp_frame[`F_CRC_HI:0]);
      end
      rxnew_q <= link.rsp_valid || (rxnew_q && !rx_rd);
    end
  end

  assign link.req_valid = req_valid_q;
  assign link.req_frame = tx_q;
endmodule : sensor_host_ctrl

// ---- sim/sensor_link_chk.sv ----
// assertions on the frame link between host controller and register bank
`timescale 1ns/1ps
module sensor_link_chk (
  // clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // frame link
  input wire logic               req_valid,
  input wire sensor_pkg::frame_t req_frame,
  input wire logic               rsp_valid,
  input wire sensor_pkg::frame_t rsp_frame
);
  import sensor_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // independent checksum so a shared slip cannot hide itself
  function automatic logic [7:0] crc_of(input logic [23:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h1d) : {c[6:0], 1'b0};
    end
    return c ^ 8'hff;
  endfunction : crc_of

  rsp_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("answer missing one cycle after a frame");
  rsp_spont_a: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without a frame");
  rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_frame))
    else $error("answer frame moved without strobe");
  req_hold_a: assert property (!req_valid |-> $stable(req_frame))
    else $error("request frame moved without strobe");
  rs_code_a: assert property (rsp_valid |->
    (rsp_frame[25:24] == 2'b01 || rsp_frame[25:24] == 2'b11))
    else $error("return status code illegal");
  req_rs_a: assert property (req_valid |-> req_frame[25:24] == 2'b00)
    else $error("request carries status bits");
  rsp_crc_a: assert property (rsp_valid |->
    rsp_frame[7:0] == crc_of(rsp_frame[31:8]))
    else $error("answer checksum wrong");
  req_crc_a: assert property (req_valid |->
    req_frame[7:0] == crc_of(req_frame[31:8]))
    else $error("request checksum wrong");
  reset_state_a: assert property ($rose(resetn) |->
    (!rsp_valid && rsp_frame == 32'h0))
    else $error("answer side not cleared by reset");

  cover property (rsp_valid && rsp_frame[25:24] == 2'b11);
  cover property (rsp_valid && rsp_frame[25:24] == 2'b01);
  cover property (rsp_valid && rsp_frame[31:26] == 6'h2d);
endmodule : sensor_link_chk

// ---- sim/tb.sv ----
// self-checking bench: host controller and register bank on one link
`timescale 1ns/1ps
`include "sensor_defs.svh"
module tb;
  import sensor_pkg::*;
  localparam logic [5:0] RD_ST = {1'b0, `REG_STATUS};
  localparam logic [5:0] RD_E1 = {1'b0, `REG_ERR1};
  localparam logic [5:0] RD_E2 = {1'b0, `REG_ERR2};
  localparam logic [5:0] RD_CM = {1'b0, `REG_CMD};
  localparam logic [5:0] WR_CM = {1'b1, `REG_CMD};
  localparam logic [5:0] WR_AN = {1'b1, `REG_ANGLE};
  localparam logic [5:0] RD_AN = {1'b0, `REG_ANGLE};
  localparam logic [5:0] WR_E1 = {1'b1, `REG_ERR1};

  logic        clk = 1'b0;
  logic        resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] e1, e2, lat;
  logic [4:0]  angle_enable, ang;
  mode_t       op_mode;
  logic [1:0]  md;
  logic        power_down, soft_reset, mc, pc, dp, pd, skp;
  logic [21:0] pend[$];
  int          n_sr = 0;
  int          seed, err_total, checks_done;

  frame_if lnk ();
  sensor_host_ctrl u_sensor_host_ctrl (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  sensor_regs_dev u_sensor_regs_dev (.clk(clk), .resetn(resetn),
    .link(lnk), .err1_src(e1), .err2_src(e2), .op_mode(op_mode),
    .power_down(power_down), .angle_enable(angle_enable),
    .soft_reset(soft_reset));
  sensor_link_chk u_sensor_link_chk (.clk(clk), .resetn(resetn),
    .req_valid(lnk.req_valid), .req_frame(lnk.req_frame),
    .rsp_valid(lnk.rsp_valid), .rsp_frame(lnk.rsp_frame));

  always #5 clk = ~clk;
  always @(posedge clk) if (soft_reset === 1'b1) n_sr <= n_sr + 1;

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // read before the edge's register updates land: these are edge values
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) chk("pready", 32'd1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] e2v();
    return (e2 & `ERR2_MASK) | {6'h0, mc, pc | pd, 3'h0, dp, 4'h0};
  endfunction : e2v

  function automatic logic [15:0] summ(input logic [15:0] a, b);
    return {8'h00, b[0], |a[11:1], b[1], |{b[11], b[5:2]},
            a[0] | b[7], b[8], b[9], |b[14:12]};
  endfunction : summ

  // send one frame, then collect and check the answer to the one before
  task automatic xfer(input logic [5:0] op, input logic [15:0] d);
    logic [31:0] q;
    logic [31:0] st;
    logic        er, s;
    logic [21:0] p;
    logic [15:0] v;
    logic [23:0] x;
    int          n;
    s = 1'b0;
    apb(1'b1, `H_TX, {8'h00, op, 2'b00, d}, q, er);
    lat = lat | summ(e1, e2v());
    p = pend.pop_front();
    v = p[21] ? p[15:0] : (p[20:16] == `REG_STATUS) ? lat :
        (p[20:16] == `REG_ERR1) ? (e1 & `ERR1_MASK) :
        (p[20:16] == `REG_ERR2) ? e2v() :
        (p[20:16] == `REG_CMD) ? {13'h0, pd, md} : 16'h0;
    x = {p[21:16], (lat != 16'h0) ? `RS_ERR : `RS_OK, v};
    if (p[21:16] == RD_ST) begin
      {mc, pc, dp} = 3'b000;
      lat = summ(e1, e2v());
    end
    pend.push_back({op, d});
    if (op == WR_AN) ang = d[4:0];
    if (op == WR_CM && d == `CMD_SWRST) begin
      {md, pd, ang, mc, pc, dp, lat, s} = {10'h0, 1'b1, 16'h0, 1'b1};
      pend.delete();
      pend.push_back(22'h0);
    end else if (op == WR_CM && d == `CMD_PD) begin
      {pd, pc} = 2'b11;
    end else if (op == WR_CM && d <= `CMD_MODE_HI) begin
      if (pd) {pd, pc, md} = 4'b0100;
      else if (d[1:0] != md) {mc, md} = {1'b1, d[1:0]};
    end
    n = 0;
    st = 32'h0;
    while (st[`HS_RXNEW] !== 1'b1 && n < 50) begin
      apb(1'b0, `H_STAT, 32'h0, st, er);
      n++;
    end
    chk("rx new", 32'd1, {31'h0, st[`HS_RXNEW]});
    apb(1'b0, `H_RX, 32'h0, q, er);
    if (!skp) chk("answer", {8'h0, x}, {8'h0, q[31:8]});
    if (!skp) chk("stat", {28'h0, x[17:16] == `RS_ERR, 3'b001}, st);
    skp = s;
    chk("ctl", {24'h0, pd, ang, md},
        {24'h0, power_down, angle_enable, op_mode});
  endtask : xfer

  initial begin
    #400000;
    err_total = err_total + 1;
    summarize();
  end

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {e1, e2, lat, mc, pc, pd, md, ang, skp} = '0;
    {err_total, checks_done} = '0;
    dp = 1'b1;
    seed = 21;
    pend.push_back(22'h0);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) xfer(RD_ST, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      e1 <= 16'($random(seed));
      e2 <= 16'($random(seed));
      xfer(RD_E1, 16'h0000);
      xfer(RD_E2, 16'h0000);
      xfer(RD_ST, 16'h0000);
    end
    e1 <= 16'h0;
    e2 <= 16'h0;
    xfer(WR_E1, 16'hffff);
    xfer(RD_E1, 16'h0000);
    repeat (3) xfer(RD_ST, 16'h0000);
    for (int m = 1; m < 5; m++) begin
      xfer(WR_CM, 16'(m % 4));
      xfer(RD_CM, 16'h0000);
      xfer(RD_ST, 16'h0000);
    end
    xfer(WR_AN, 16'hffff);
    xfer(RD_AN, 16'h0000);
    xfer(WR_CM, `CMD_PD);
    xfer(RD_CM, 16'h0000);
    xfer(WR_CM, 16'h0000);
    xfer(RD_CM, 16'h0000);
    xfer(WR_CM, `CMD_SWRST);
    repeat (4) xfer(RD_ST, 16'h0000);
    chk("reset pulses", 32'd1, 32'(n_sr));
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk("slverr", 32'd1, {31'h0, e});
    summarize();
  end
endmodule : tb
